// ### core/pmm_flag_latch.sv
module pmm_flag_latch #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Flag group
  pmm_flag_if.latch f
);
  logic [W-1:0] flags_q;

  // A condition present in the clearing cycle sets the bit again
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flags_q <= '0;
    end
    else
    begin
      flags_q <= (flags_q & ~{W{f.clr}}) | f.cond;
    end
  end

  assign f.flags = flags_q;

endmodule : pmm_flag_latch

// ### core/pmm_mgmt_ctrl.sv
// What this block does
// - Answer two-wire traffic only while selected
// - Select input defaults to deselected level
// - Reset pulse over 2 us restores defaults
// - Reset completion posts interrupt, not-ready cleared
// - Power-up posts completion interrupt unprompted
// - Fully functional within 2000 ms
// - Low-power input disables high-speed paths quickly
// - Open-drain interrupt, source read over port
// - Interrupt level mirrored at page 0 byte 2 bit 1
// - Presence output tied low
// - Soft controls volatile, default after reset
// - Receive loss flags byte 3 bits 0-3
// - Optical receive lane feeds two lanes each
// - Transmit loss flags byte 3 bits 4-7
// - Transmit fault latched byte 4, read-clear
// - Either lane of pair disables laser
// - Receive output disable page 3 byte 241
// - Transmit squelch disable page 3 byte 240 low
// - Receive squelch disable page 3 byte 240 high
// - Interrupt asserts within 200 ms of cause
// - Interrupt releases within 500 us of read
// - Not-ready bit 0 byte 2, clears at ready
// - Mask bit inhibits its flag's interrupt
module pmm_mgmt_ctrl #(
  parameter int INIT_CYCLES = pmm_pkg::INIT_CYC
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Sideband pins
  input  wire logic       MODULE_SELECT_N,
  input  wire logic       MODULE_RESET_N,
  input  wire logic       LOW_POWER_SELECT,
  output logic            MODULE_PRESENT_N,
  input  wire logic       INTERRUPT_N_I,
  output logic            INTERRUPT_N_O,
  output logic            INTERRUPT_N_OE_N,
  // Two-wire port
  input  wire logic       SCL,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_N,
  // Line status conditions
  input  wire logic [1:0] RX_LOS_OPT,
  input  wire logic [3:0] TX_LOS,
  input  wire logic [1:0] TX_FAULT_OPT,
  // Data path controls
  output logic            LOW_POWER_MODE,
  output logic [1:0]      TX_OPT_DISABLE,
  output logic [3:0]      RX_OUT_DISABLE,
  output logic [3:0]      TX_SQUELCH_EN,
  output logic [3:0]      RX_SQUELCH_EN,
  output logic            DATA_NOT_READY
);
  import pmm_pkg::*;

  localparam int                 INIT_W    = $clog2(INIT_CYCLES + 1);
  localparam logic [INIT_W-1:0]  INIT_LAST = INIT_W'(INIT_CYCLES - 1);
  localparam logic [7:0]         PULSE_MIN = 8'(RESET_PULSE_CYC);

  function automatic logic [3:0] pair_expand(input logic [1:0] opt);
    pair_expand = {opt[1], opt[1], opt[0], opt[0]};
  endfunction : pair_expand

  function automatic logic hit(input logic [7:0] ptr, input logic [7:0] page,
                               input logic [7:0] off);
    hit = (ptr == off) && ((off < UPPER_BASE) || (page == PAGE_CTRL));
  endfunction : hit

  // Pin synchronisers
  logic [13:0] sync1_q;
  logic [13:0] sync2_q;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      sync1_q <= RST_SYNC;
      sync2_q <= RST_SYNC;
    end
    else
    begin
      sync1_q <= {SCL, SDA_I, MODULE_SELECT_N, MODULE_RESET_N, INTERRUPT_N_I,
                  LOW_POWER_SELECT, RX_LOS_OPT, TX_LOS, TX_FAULT_OPT};
      sync2_q <= sync1_q;
    end
  end

  logic       scl_s;
  logic       sda_s;
  logic       sel_n_s;
  logic       rstn_s;
  logic       irq_pin_s;
  logic       lp_s;
  logic [1:0] rx_los_s;
  logic [3:0] tx_los_s;
  logic [1:0] fault_s;

  assign scl_s     = sync2_q[13];
  assign sda_s     = sync2_q[12];
  assign sel_n_s   = sync2_q[11];
  assign rstn_s    = sync2_q[10];
  assign irq_pin_s = sync2_q[9];
  assign lp_s      = sync2_q[8];
  assign rx_los_s  = sync2_q[7:6];
  assign tx_los_s  = sync2_q[5:2];
  assign fault_s   = sync2_q[1:0];

  // Module reset pin: pulse width and release
  logic [7:0] low_cnt_q;
  logic       long_low;
  logic       held_in_reset;
  logic       reset_release;
  logic       user_rst;

  always_ff @(posedge CLK)
  begin
    if (RST || rstn_s)
    begin
      low_cnt_q <= 8'h00;
    end
    else if (low_cnt_q < PULSE_MIN)
    begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end

  assign long_low      = (low_cnt_q >= PULSE_MIN);
  assign held_in_reset = !rstn_s && long_low;
  assign reset_release = rstn_s && long_low;
  assign user_rst      = RST || held_in_reset || reset_release;

  // Initialisation timer and completion flag
  logic [INIT_W-1:0] init_cnt_q;
  logic              dnr_q;
  logic              init_done;
  logic              init_flag_q;
  logic              init_clr;

  assign init_done = dnr_q && (init_cnt_q == INIT_LAST);

  always_ff @(posedge CLK)
  begin
    if (user_rst)
    begin
      dnr_q      <= 1'b1;
      init_cnt_q <= '0;
    end
    else if (init_done)
    begin
      dnr_q <= 1'b0;
    end
    else if (dnr_q)
    begin
      init_cnt_q <= init_cnt_q + INIT_W'(1);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (user_rst)
    begin
      init_flag_q <= 1'b0;
    end
    else
    begin
      init_flag_q <= (init_flag_q & ~init_clr) | init_done;
    end
  end

  // Two-wire port engine
  pmm_tws_state_t st_q;
  logic [3:0]     cnt_q;
  logic [7:0]     sh_q;
  logic [7:0]     tx_q;
  logic [7:0]     ptr_q;
  logic           rw_q;
  logic           oe_n_q;
  logic           scl_p_q;
  logic           sda_p_q;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_c;
  logic           stop_c;
  logic           fall_ok;
  logic           rd_take;
  logic           wr_take;
  logic [7:0]     rd_byte;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  assign start_c  = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_c   = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign fall_ok  = !RST && !sel_n_s && !start_c && !stop_c && scl_fall;
  assign rd_take  = fall_ok && (((st_q == ST_AACK) && rw_q) || (st_q == ST_RACK));
  assign wr_take  = fall_ok && (st_q == ST_DATA) && (cnt_q == 4'h8);

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      st_q   <= ST_IDLE;
      cnt_q  <= 4'h0;
      sh_q   <= 8'h00;
      tx_q   <= 8'h00;
      ptr_q  <= 8'h00;
      rw_q   <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else if (sel_n_s)
    begin
      st_q   <= ST_IDLE;
      oe_n_q <= 1'b1;
    end
    else if (start_c)
    begin
      st_q   <= ST_ADDR;
      cnt_q  <= 4'h0;
      oe_n_q <= 1'b1;
    end
    else if (stop_c)
    begin
      st_q   <= ST_IDLE;
      oe_n_q <= 1'b1;
    end
    else if (scl_rise)
    begin
      case (st_q)
        ST_ADDR, ST_PTR, ST_DATA:
        begin
          sh_q  <= {sh_q[6:0], sda_s};
          cnt_q <= cnt_q + 4'h1;
        end
        ST_RD:   cnt_q <= cnt_q + 4'h1;
        ST_RACK: if (sda_s) st_q <= ST_IDLE;
        default: ;
      endcase
    end
    else if (scl_fall)
    begin
      case (st_q)
        ST_ADDR:
          if (cnt_q == 4'h8)
          begin
            if (sh_q[7:1] == DEV_ADDR)
            begin
              st_q   <= ST_AACK;
              oe_n_q <= 1'b0;
              rw_q   <= sh_q[0];
            end
            else
            begin
              st_q <= ST_IDLE;
            end
          end
        ST_AACK, ST_RACK:
        begin
          cnt_q <= 4'h0;
          if (rw_q)
          begin
            st_q   <= ST_RD;
            tx_q   <= rd_byte;
            oe_n_q <= rd_byte[7];
            ptr_q  <= ptr_q + 8'h01;
          end
          else
          begin
            st_q   <= ST_PTR;
            oe_n_q <= 1'b1;
          end
        end
        ST_PTR:
          if (cnt_q == 4'h8)
          begin
            ptr_q  <= sh_q;
            st_q   <= ST_WACK;
            oe_n_q <= 1'b0;
          end
        ST_DATA:
          if (cnt_q == 4'h8)
          begin
            ptr_q  <= ptr_q + 8'h01;
            st_q   <= ST_WACK;
            oe_n_q <= 1'b0;
          end
        ST_WACK:
        begin
          cnt_q  <= 4'h0;
          st_q   <= ST_DATA;
          oe_n_q <= 1'b1;
        end
        ST_RD:
          if (cnt_q == 4'h8)
          begin
            st_q   <= ST_RACK;
            oe_n_q <= 1'b1;
          end
          else
          begin
            oe_n_q <= tx_q[~cnt_q[2:0]];
          end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Soft controls
  logic [7:0] page_q;
  logic [7:0] tx_dis_q;
  logic [7:0] sq_dis_q;
  logic [3:0] rx_dis_q;
  logic [7:0] los_mask_q;
  logic [7:0] fault_mask_q;

  always_ff @(posedge CLK)
  begin
    if (user_rst)
    begin
      page_q       <= RST_PAGE;
      tx_dis_q     <= RST_CTRL;
      sq_dis_q     <= RST_CTRL;
      rx_dis_q     <= RST_CTRL[3:0];
      los_mask_q   <= RST_CTRL;
      fault_mask_q <= RST_CTRL;
    end
    else if (wr_take)
    begin
      if (hit(ptr_q, page_q, OFF_PAGE_SELECT)) page_q <= sh_q;
      if (hit(ptr_q, page_q, OFF_TX_DISABLE)) tx_dis_q <= sh_q;
      if (hit(ptr_q, page_q, OFF_SQUELCH_DIS)) sq_dis_q <= sh_q;
      if (hit(ptr_q, page_q, OFF_RX_OUT_DIS)) rx_dis_q <= sh_q[RX_DIS_LSB +: 4];
      if (hit(ptr_q, page_q, OFF_LOS_MASK)) los_mask_q <= sh_q;
      if (hit(ptr_q, page_q, OFF_FAULT_MASK)) fault_mask_q <= sh_q;
    end
  end

  // Latched status flags
  pmm_flag_if #(.W(8)) los_if ();
  pmm_flag_if #(.W(8)) fault_if ();

  assign los_if.cond   = {tx_los_s, pair_expand(rx_los_s)};
  assign los_if.clr    = rd_take && hit(ptr_q, page_q, OFF_LOS_FLAGS);
  assign fault_if.cond = {4'h0, pair_expand(fault_s)};
  assign fault_if.clr  = rd_take && hit(ptr_q, page_q, OFF_TX_FAULT);
  assign init_clr      = rd_take && hit(ptr_q, page_q, OFF_IRQ_STATUS);

  pmm_flag_latch #(.W(8)) u_los_flags (
    .clk (CLK),
    .rst (user_rst),
    .f   (los_if.latch)
  );

  pmm_flag_latch #(.W(8)) u_fault_flags (
    .clk (CLK),
    .rst (user_rst),
    .f   (fault_if.latch)
  );

  // Read data for the byte at the pointer
  always_comb
  begin
    rd_byte = 8'h00;
    if (hit(ptr_q, page_q, OFF_IRQ_STATUS))
    begin
      rd_byte[BIT_DATA_NOT_READY] = dnr_q;
      rd_byte[BIT_IRQ_MIRROR]     = irq_pin_s;
    end
    if (hit(ptr_q, page_q, OFF_LOS_FLAGS)) rd_byte = los_if.flags;
    if (hit(ptr_q, page_q, OFF_TX_FAULT)) rd_byte = fault_if.flags;
    if (hit(ptr_q, page_q, OFF_TX_DISABLE)) rd_byte = tx_dis_q;
    if (hit(ptr_q, page_q, OFF_LOS_MASK)) rd_byte = los_mask_q;
    if (hit(ptr_q, page_q, OFF_FAULT_MASK)) rd_byte = fault_mask_q;
    if (hit(ptr_q, page_q, OFF_PAGE_SELECT)) rd_byte = page_q;
    if (hit(ptr_q, page_q, OFF_SQUELCH_DIS)) rd_byte = sq_dis_q;
    if (hit(ptr_q, page_q, OFF_RX_OUT_DIS)) rd_byte = {rx_dis_q, 4'h0};
  end

  // Interrupt request
  logic irq_req;
  logic irq_oe_n_q;

  assign irq_req = init_flag_q
                || |(los_if.flags & ~los_mask_q)
                || |(fault_if.flags & ~fault_mask_q);

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      irq_oe_n_q <= 1'b1;
    end
    else
    begin
      irq_oe_n_q <= !irq_req;
    end
  end

  // Data path controls
  logic       lp_q;
  logic [1:0] tx_opt_dis_q;
  logic [3:0] rx_out_dis_q;
  logic [3:0] tx_sq_en_q;
  logic [3:0] rx_sq_en_q;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      lp_q         <= 1'b0;
      tx_opt_dis_q <= 2'h3;
      rx_out_dis_q <= 4'hF;
      tx_sq_en_q   <= 4'hF;
      rx_sq_en_q   <= 4'hF;
    end
    else
    begin
      lp_q            <= lp_s;
      tx_opt_dis_q[0] <= |tx_dis_q[1:0] || lp_s;
      tx_opt_dis_q[1] <= |tx_dis_q[3:2] || lp_s;
      rx_out_dis_q    <= rx_dis_q | {4{lp_s}};
      tx_sq_en_q      <= ~sq_dis_q[SQ_TX_LSB +: 4];
      rx_sq_en_q      <= ~sq_dis_q[SQ_RX_LSB +: 4];
    end
  end

  assign MODULE_PRESENT_N = 1'b0;
  assign INTERRUPT_N_O    = 1'b0;
  assign INTERRUPT_N_OE_N = irq_oe_n_q;
  assign SDA_O            = 1'b0;
  assign SDA_OE_N         = oe_n_q;
  assign LOW_POWER_MODE   = lp_q;
  assign TX_OPT_DISABLE   = tx_opt_dis_q;
  assign RX_OUT_DISABLE   = rx_out_dis_q;
  assign TX_SQUELCH_EN    = tx_sq_en_q;
  assign RX_SQUELCH_EN    = rx_sq_en_q;
  assign DATA_NOT_READY   = dnr_q;

endmodule : pmm_mgmt_ctrl

// ### include/pmm_flag_if.sv
interface pmm_flag_if #(parameter int W = 8);
  logic [W-1:0] cond;
  logic [W-1:0] flags;
  logic         clr;

  modport latch (input cond, input clr, output flags);
  modport user  (output cond, output clr, input flags);
endinterface : pmm_flag_if

// ### include/pmm_pkg.sv
package pmm_pkg;

  // Clock and timing
  localparam int CLK_FREQ_MHZ    = 100;
  localparam int T_RESET_INIT_US = 2;
  localparam int RESET_PULSE_CYC = T_RESET_INIT_US * CLK_FREQ_MHZ;
  localparam int T_INIT_MS       = 2000;
  localparam int INIT_CYC        = T_INIT_MS * 1000 * CLK_FREQ_MHZ;

  // Two-wire port
  localparam logic [6:0] DEV_ADDR   = 7'h50;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [7:0] PAGE_CTRL  = 8'h03;

  // Register offsets
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h02;
  localparam logic [7:0] OFF_LOS_FLAGS   = 8'h03;
  localparam logic [7:0] OFF_TX_FAULT    = 8'h04;
  localparam logic [7:0] OFF_TX_DISABLE  = 8'h56;
  localparam logic [7:0] OFF_LOS_MASK    = 8'h64;
  localparam logic [7:0] OFF_FAULT_MASK  = 8'h65;
  localparam logic [7:0] OFF_PAGE_SELECT = 8'h7F;
  localparam logic [7:0] OFF_SQUELCH_DIS = 8'hF0;
  localparam logic [7:0] OFF_RX_OUT_DIS  = 8'hF1;

  // Field positions
  localparam int BIT_DATA_NOT_READY = 0;
  localparam int BIT_IRQ_MIRROR     = 1;
  localparam int LOS_RX_LSB         = 0;
  localparam int LOS_TX_LSB         = 4;
  localparam int SQ_TX_LSB          = 0;
  localparam int SQ_RX_LSB          = 4;
  localparam int RX_DIS_LSB         = 4;

  // Reset values
  localparam logic [7:0]  RST_CTRL = 8'h00;
  localparam logic [7:0]  RST_PAGE = 8'h00;
  // Pin synchroniser order: scl sda sel_n reset_n irq lp rxlos[2] txlos[4] fault[2]
  localparam logic [13:0] RST_SYNC = 14'h3E00;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_AACK = 4'h2,
    ST_PTR  = 4'h3,
    ST_DATA = 4'h4,
    ST_WACK = 4'h5,
    ST_RD   = 4'h6,
    ST_RACK = 4'h7
  } pmm_tws_state_t;

endpackage : pmm_pkg

// ### tb/pmm_host_model.sv
module pmm_host_model
(
  // Bus wires
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import pmm_pkg::*;

  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  // Quarter of an 80 ns bus clock
  task automatic q();
    repeat (2) @(negedge clk);
  endtask : q

  task automatic bitx(input logic b, output logic r);
    sda_oe = !b;
    q();
    scl = 1'b1;
    q();
    q();
    r = sda;
    scl = 1'b0;
    q();
  endtask : bitx

  task automatic start();
    sda_oe = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_oe = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask : start

  task automatic stop();
    sda_oe = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_oe = 1'b0;
    q();
  endtask : stop

  // Sends d MSB first, then the ninth bit; ack is the device pulling low
  task automatic byte_x(input logic [7:0] d, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(1'b1, a);
    ack = !a;
  endtask : byte_x

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic ack);
    logic [7:0] r;
    logic       a1;
    logic       a2;
    start();
    byte_x({DEV_ADDR, 1'b0}, r, a1);
    byte_x(ptr, r, a2);
    byte_x(d, r, ack);
    ack = ack & a1 & a2;
    stop();
  endtask : wr

  task automatic rd(input logic [7:0] ptr, output logic [7:0] d, output logic ack);
    logic a1;
    logic a2;
    logic a3;
    start();
    byte_x({DEV_ADDR, 1'b0}, d, a1);
    byte_x(ptr, d, a2);
    start();
    byte_x({DEV_ADDR, 1'b1}, d, a3);
    byte_x(8'hFF, d, ack);
    ack = a1 & a2 & a3;
    stop();
  endtask : rd
endmodule : pmm_host_model

// ### tb/pmm_mgmt_ctrl_sva.sv
module pmm_mgmt_ctrl_sva
(
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RST,
  // Sideband and port pins
  input wire logic       MODULE_SELECT_N,
  input wire logic       MODULE_RESET_N,
  input wire logic       LOW_POWER_SELECT,
  input wire logic       MODULE_PRESENT_N,
  input wire logic       INTERRUPT_N_O,
  input wire logic       INTERRUPT_N_OE_N,
  input wire logic       SDA_O,
  input wire logic       SDA_OE_N,
  // Data path controls
  input wire logic       LOW_POWER_MODE,
  input wire logic [1:0] TX_OPT_DISABLE,
  input wire logic [3:0] RX_OUT_DISABLE,
  input wire logic [3:0] TX_SQUELCH_EN,
  input wire logic [3:0] RX_SQUELCH_EN,
  input wire logic       DATA_NOT_READY
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] low_cnt_q;

  // Consecutive cycles with the reset pin low
  always_ff @(posedge CLK)
  begin
    if (RST || MODULE_RESET_N) low_cnt_q <= 8'h00;
    else if (low_cnt_q != 8'hFF) low_cnt_q <= low_cnt_q + 8'h01;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  present_low_a: assert property (MODULE_PRESENT_N == 1'b0)
    else $error("presence output not low");
  open_drain_a: assert property (INTERRUPT_N_O == 1'b0 && SDA_O == 1'b0)
    else $error("open drain data not low");
  desel_quiet_a: assert property (MODULE_SELECT_N [*4] |-> SDA_OE_N)
    else $error("data line driven while deselected");
  lp_force_a: assert property (LOW_POWER_SELECT [*5] |->
    TX_OPT_DISABLE == 2'h3 && RX_OUT_DISABLE == 4'hF)
    else $error("outputs live in low power");
  lp_entry_a: assert property ($rose(LOW_POWER_SELECT) |-> ##[1:4] LOW_POWER_MODE)
    else $error("low power entry late");
  ready_irq_a: assert property ($fell(DATA_NOT_READY) |-> ##[0:2] !INTERRUPT_N_OE_N)
    else $error("no completion interrupt");
  reset_dflt_a: assert property (low_cnt_q > 8'hCD |-> DATA_NOT_READY &&
    TX_SQUELCH_EN == 4'hF && RX_SQUELCH_EN == 4'hF)
    else $error("defaults not held in reset");
  dnr_cause_a: assert property ($rose(DATA_NOT_READY) |->
    !MODULE_RESET_N && low_cnt_q > 8'hC7)
    else $error("not ready without long reset");

  cover property ($fell(INTERRUPT_N_OE_N));
  cover property ($rose(LOW_POWER_MODE));
  cover property (low_cnt_q == 8'hCE);
endmodule : pmm_mgmt_ctrl_sva

bind pmm_mgmt_ctrl pmm_mgmt_ctrl_sva i_sva (.CLK(CLK), .RST(RST),
  .MODULE_SELECT_N(MODULE_SELECT_N), .MODULE_RESET_N(MODULE_RESET_N),
  .LOW_POWER_SELECT(LOW_POWER_SELECT), .MODULE_PRESENT_N(MODULE_PRESENT_N),
  .INTERRUPT_N_O(INTERRUPT_N_O), .INTERRUPT_N_OE_N(INTERRUPT_N_OE_N), .SDA_O(SDA_O),
  .SDA_OE_N(SDA_OE_N), .LOW_POWER_MODE(LOW_POWER_MODE), .TX_OPT_DISABLE(TX_OPT_DISABLE),
  .RX_OUT_DISABLE(RX_OUT_DISABLE), .TX_SQUELCH_EN(TX_SQUELCH_EN),
  .RX_SQUELCH_EN(RX_SQUELCH_EN), .DATA_NOT_READY(DATA_NOT_READY));

// ### tb/pmm_mgmt_ctrl_tb.sv
module pmm_mgmt_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmm_pkg::*;
  localparam int INIT = 50;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       sel_n = 1'b0;
  logic       rst_n = 1'b1;
  logic       lp = 1'b0;
  logic [1:0] rx_los = 2'h0;
  logic [3:0] tx_los = 4'h0;
  logic [1:0] fault = 2'h0;
  logic       present_n, irq_o, irq_oe_n, sda_o, sda_oe_n, lp_mode, dnr, scl, host_oe, ack;
  logic [1:0] tx_dis;
  logic [3:0] rx_dis, tx_sq, rx_sq;
  logic [7:0] rd_v;
  int         fail_count = 0;
  int         samples_checked = 0;
  // Pulled-up wires: low when any party pulls
  wire        sda_w = !(host_oe || !sda_oe_n);
  wire        irq_w = irq_oe_n ? 1'b1 : irq_o;

  always #5 clk = ~clk;

  pmm_mgmt_ctrl #(.INIT_CYCLES(INIT)) i_dut (.CLK(clk), .RST(rst), .MODULE_SELECT_N(sel_n),
    .MODULE_RESET_N(rst_n), .LOW_POWER_SELECT(lp), .MODULE_PRESENT_N(present_n),
    .INTERRUPT_N_I(irq_w), .INTERRUPT_N_O(irq_o), .INTERRUPT_N_OE_N(irq_oe_n), .SCL(scl),
    .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .RX_LOS_OPT(rx_los), .TX_LOS(tx_los),
    .TX_FAULT_OPT(fault), .LOW_POWER_MODE(lp_mode), .TX_OPT_DISABLE(tx_dis),
    .RX_OUT_DISABLE(rx_dis), .TX_SQUELCH_EN(tx_sq), .RX_SQUELCH_EN(rx_sq),
    .DATA_NOT_READY(dnr));

  pmm_host_model i_host (.clk(clk), .sda(sda_w), .scl(scl), .sda_oe(host_oe));

  task automatic complete_run();
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic rdc(input logic [7:0] ptr, input logic [7:0] exp);
    i_host.rd(ptr, rd_v, ack);
    chk({7'h0, ack}, 8'h01);
    chk(rd_v, exp);
  endtask : rdc

  task automatic wrc(input logic [7:0] ptr, input logic [7:0] d);
    i_host.wr(ptr, d, ack);
    chk({7'h0, ack}, 8'h01);
  endtask : wrc

  task automatic irq(input logic exp);
    chk({7'h0, irq_oe_n}, {7'h0, exp});
  endtask : irq

  task automatic t_ready();
    for (int i = 0; i < INIT + 20 && dnr !== 1'b0; i++) cyc(1);
    chk({7'h0, dnr}, 8'h00);
    cyc(2);
    irq(1'b0);
    rdc(OFF_IRQ_STATUS, 8'h00);
    cyc(4);
    irq(1'b1);
    rdc(OFF_IRQ_STATUS, 8'h02);
  endtask : t_ready

  task automatic t_controls();
    rdc(OFF_TX_DISABLE, 8'h00);
    chk({tx_sq, rx_sq}, 8'hFF);
    wrc(OFF_PAGE_SELECT, PAGE_CTRL);
    rdc(OFF_PAGE_SELECT, PAGE_CTRL);
    rdc(OFF_SQUELCH_DIS, 8'h00);
    wrc(OFF_SQUELCH_DIS, 8'hA5);
    wrc(OFF_RX_OUT_DIS, 8'h50);
    rdc(OFF_SQUELCH_DIS, 8'hA5);
    chk({tx_sq, rx_sq}, 8'hA5);
    chk({4'h0, rx_dis}, 8'h05);
    wrc(OFF_TX_DISABLE, 8'h04);
    chk({6'h0, tx_dis}, 8'h02);
    wrc(OFF_TX_DISABLE, 8'h01);
    chk({6'h0, tx_dis}, 8'h01);
  endtask : t_controls

  task automatic t_flags();
    rx_los = 2'h2;
    tx_los = 4'h1;
    cyc(3);
    rx_los = 2'h0;
    tx_los = 4'h0;
    cyc(10);
    irq(1'b0);
    rdc(OFF_LOS_FLAGS, 8'h1C);
    cyc(4);
    irq(1'b1);
    rdc(OFF_LOS_FLAGS, 8'h00);
  endtask : t_flags

  task automatic t_fault();
    fault = 2'h1;
    cyc(10);
    rdc(OFF_TX_FAULT, 8'h03);
    rdc(OFF_TX_FAULT, 8'h03);
    fault = 2'h0;
    rdc(OFF_TX_FAULT, 8'h03);
    rdc(OFF_TX_FAULT, 8'h00);
    cyc(4);
    irq(1'b1);
  endtask : t_fault

  task automatic t_mask();
    wrc(OFF_LOS_MASK, 8'hFF);
    rx_los = 2'h1;
    cyc(3);
    rx_los = 2'h0;
    cyc(10);
    irq(1'b1);
    wrc(OFF_LOS_MASK, 8'h00);
    cyc(6);
    irq(1'b0);
    rdc(OFF_LOS_FLAGS, 8'h03);
    cyc(4);
    irq(1'b1);
    wrc(OFF_FAULT_MASK, 8'h0C);
    fault = 2'h2;
    cyc(3);
    fault = 2'h0;
    cyc(10);
    irq(1'b1);
    rdc(OFF_FAULT_MASK, 8'h0C);
    rdc(OFF_TX_FAULT, 8'h0C);
    wrc(OFF_FAULT_MASK, 8'h00);
    irq(1'b1);
  endtask : t_mask

  task automatic t_lowpower();
    lp = 1'b1;
    cyc(5);
    chk({lp_mode, 1'b0, tx_dis, rx_dis}, 8'hBF);
    rdc(OFF_SQUELCH_DIS, 8'hA5);
    lp = 1'b0;
    cyc(5);
    chk({lp_mode, 1'b0, tx_dis, rx_dis}, 8'h15);
  endtask : t_lowpower

  task automatic t_deselect();
    sel_n = 1'b1;
    cyc(10);
    i_host.rd(OFF_IRQ_STATUS, rd_v, ack);
    chk({7'h0, ack}, 8'h00);
    chk(rd_v, 8'hFF);
    sel_n = 1'b0;
    cyc(10);
  endtask : t_deselect

  task automatic t_pin_reset();
    rst_n = 1'b0;
    cyc(210);
    chk({dnr, 1'b0, tx_dis, tx_sq}, 8'h8F);
    rst_n = 1'b1;
    t_ready();
    rdc(OFF_TX_DISABLE, 8'h00);
    rdc(OFF_PAGE_SELECT, RST_PAGE);
  endtask : t_pin_reset

  initial
  begin
    cyc(4);
    rst = 1'b0;
    t_ready();
    t_controls();
    t_flags();
    t_fault();
    t_mask();
    t_lowpower();
    t_deselect();
    t_pin_reset();
    complete_run();
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    fail_count++;
    complete_run();
  end
endmodule : pmm_mgmt_ctrl_tb
